// ---- hdl/sbc_params.svh ----
// Purpose: Offsets, field positions, reset values and codes of the counter block
// Assumes: Included once per compilation unit through the guard
// Notes:   Byte addresses on the AXI4-Lite register bus
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH

// Register byte offsets
`define SBC_CTRL_OFS       4'h0
`define SBC_PRESET_OFS     4'h4
`define SBC_STATUS_OFS     4'h8

// Control register fields
`define SBC_CTRL_CLEAR_BIT 0
`define SBC_CTRL_LOAD_BIT  1
`define SBC_CTRL_GATE_BIT  2

// Status register fields
`define SBC_STAT_TERM_BIT  4
`define SBC_STAT_KNOWN_BIT 5

// Reset values and constants
`define SBC_GATE_RST       1'h1
`define SBC_PRESET_RST     4'h0
`define SBC_COUNT_MAX      4'hf
`define SBC_RESP_OKAY      2'h0
`define SBC_RESP_SLVERR    2'h2

`endif

// ---- hdl/sbc_pkg.sv ----
// Purpose: Types shared by the counter block
// Assumes: sbc_params.svh holds every number
// Notes:   State of the top module is one packed struct
package sbc_pkg;

	typedef logic [3:0] sbc_nibble_t;
	typedef logic [3:0] sbc_addr_t;

	// Operating modes in order of precedence
	typedef enum logic [1:0] {
		SBC_MODE_CLEAR,
		SBC_MODE_LOAD,
		SBC_MODE_COUNT,
		SBC_MODE_HOLD
	} sbc_mode_t;

	// Whole state of the counter module
	typedef struct packed {
		sbc_nibble_t count;
		logic        count_known;
		logic        sw_clear;
		logic        sw_load;
		logic        count_gate;
		sbc_nibble_t preset;
		logic        aw_held;
		sbc_addr_t   aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} sbc_state_t;

endpackage

// ---- hdl/sbc_counter.sv ----
// Purpose: 4-bit synchronous up-counter with clear, load, two enables and terminal count
// Assumes: All pins come from logic on the same clock; AXI4-Lite master on that clock
// Notes:   rst_n clears the bus side except the gate bit, which it sets, and clears the count-known flag; the count itself has no asynchronous reset
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`include "sbc_params.svh"

// Function
// - Four-bit count steps through sixteen states, wrapping fifteen to zero.
// - Count changes only on the rising clock edge, never on the falling one.
// - Mode priority: clear, then load, then count, else hold.
// - Clear low at a rising edge forces the count to zero.
// - Load low with clear high copies the load value into the count.
// - Clear and load high, both enables high: count increments by one; here the gate bit of the control register must also be set.
// - Clear and load high, either enable low: count holds.
// - Terminal count is high when trickle enable is high and count is fifteen.
// - Control inputs are sampled only at the rising edge.
module sbc_counter
	import sbc_pkg::*;
(
	// Clock and bus reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Counter control pins
	input  wire logic        sync_clear_n,
	input  wire logic        load_enable_n,
	input  wire logic        count_enable_parallel,
	input  wire logic        count_enable_trickle,
	input  wire sbc_nibble_t load_value,
	// Counter outputs
	output sbc_nibble_t      count_value,
	output logic             terminal_count,
	// AXI4-Lite write address and data
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire sbc_addr_t   s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire sbc_addr_t   s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);

	sbc_state_t st;
	sbc_state_t next_st;
	sbc_mode_t  mode;
	logic       clear_req;
	logic       load_req;
	logic       count_en;
	logic       aw_now;
	logic       w_now;
	sbc_addr_t  wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;

	// Fixed-precedence mode decode, shared by logic and checks
	function automatic sbc_mode_t sbc_mode_of(input logic clr, input logic ld, input logic en);
		if (clr) begin
			return SBC_MODE_CLEAR;
		end else if (ld) begin
			return SBC_MODE_LOAD;
		end else if (en) begin
			return SBC_MODE_COUNT;
		end
		return SBC_MODE_HOLD;
	endfunction

	// Address decode, shared by read and write paths
	function automatic logic sbc_mapped(input sbc_addr_t a);
		return (a == `SBC_CTRL_OFS) || (a == `SBC_PRESET_OFS) || (a == `SBC_STATUS_OFS);
	endfunction

	// sampled at edge: requests from pins and from one-cycle software pulses
	assign clear_req = !sync_clear_n || st.sw_clear;
	assign load_req  = !load_enable_n || st.sw_load;
	assign count_en  = count_enable_parallel && count_enable_trickle && st.count_gate;
	assign mode      = sbc_mode_of(clear_req, load_req, count_en);

	// terminal count decode; combinational, so it may spike between edges
	assign terminal_count = count_enable_trickle && (st.count == `SBC_COUNT_MAX);
	assign count_value    = st.count;

	// Bus handshake outputs; a pending response blocks new writes
	assign s_axi_awready = !st.aw_held && !st.bvalid;
	assign s_axi_wready  = !st.w_held && !st.bvalid;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;

	// Address and data may arrive in either order; use held copy or live bus
	assign aw_now  = st.aw_held || (s_axi_awvalid && s_axi_awready);
	assign w_now   = st.w_held || (s_axi_wvalid && s_axi_wready);
	assign wr_addr = st.aw_held ? st.aw_addr : s_axi_awaddr;
	assign wr_data = st.w_held ? st.w_data : s_axi_wdata;
	assign wr_strb = st.w_held ? st.w_strb : s_axi_wstrb;

	// Next-state logic for counter and register slave
	always_comb begin
		next_st = st;
		// Software pulses last exactly one cycle
		next_st.sw_clear = 1'b0;
		next_st.sw_load  = 1'b0;
		case (mode)
			SBC_MODE_CLEAR: begin
				next_st.count       = 4'h0;
				next_st.count_known = 1'b1;
			end
			SBC_MODE_LOAD: begin
				next_st.count       = !load_enable_n ? load_value : st.preset;
				next_st.count_known = 1'b1;
			end
			SBC_MODE_COUNT: begin
				next_st.count = st.count + 4'h1;
			end
			SBC_MODE_HOLD: begin
				next_st.count = st.count;
			end
			default: begin
				next_st.count = st.count;
			end
		endcase
		// Capture write halves that arrive alone
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		// Both halves present: perform the write and raise the response
		if (aw_now && w_now && !st.bvalid) begin
			next_st.aw_held = 1'b0;
			next_st.w_held  = 1'b0;
			next_st.bvalid  = 1'b1;
			next_st.bresp   = sbc_mapped(wr_addr) ? `SBC_RESP_OKAY : `SBC_RESP_SLVERR;
			if (wr_strb[0] && wr_addr == `SBC_CTRL_OFS) begin
				next_st.sw_clear   = wr_data[`SBC_CTRL_CLEAR_BIT];
				next_st.sw_load    = wr_data[`SBC_CTRL_LOAD_BIT];
				next_st.count_gate = wr_data[`SBC_CTRL_GATE_BIT];
			end
			if (wr_strb[0] && wr_addr == `SBC_PRESET_OFS) begin
				next_st.preset = wr_data[3:0];
			end
		end else if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// Read answer one cycle after the address is taken
		if (s_axi_arvalid && s_axi_arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp  = sbc_mapped(s_axi_araddr) ? `SBC_RESP_OKAY : `SBC_RESP_SLVERR;
			next_st.rdata  = 32'h0;
			case (s_axi_araddr)
				`SBC_CTRL_OFS: begin
					next_st.rdata[`SBC_CTRL_GATE_BIT] = st.count_gate;
				end
				`SBC_PRESET_OFS: begin
					next_st.rdata[3:0] = st.preset;
				end
				`SBC_STATUS_OFS: begin
					next_st.rdata[3:0]                 = st.count;
					next_st.rdata[`SBC_STAT_TERM_BIT]  = terminal_count;
					next_st.rdata[`SBC_STAT_KNOWN_BIT] = st.count_known;
				end
				default: begin
					next_st.rdata = 32'h0;
				end
			endcase
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
	end

	// rising edge only; reset leaves count alone, it holds while rst_n is low
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st.count_known <= 1'b0;
			st.sw_clear    <= 1'b0;
			st.sw_load     <= 1'b0;
			st.count_gate  <= `SBC_GATE_RST;
			st.preset      <= `SBC_PRESET_RST;
			st.aw_held     <= 1'b0;
			st.aw_addr     <= 4'h0;
			st.w_held      <= 1'b0;
			st.w_data      <= 32'h0;
			st.w_strb      <= 4'h0;
			st.bvalid      <= 1'b0;
			st.bresp       <= 2'h0;
			st.rvalid      <= 1'b0;
			st.rdata       <= 32'h0;
			st.rresp       <= 2'h0;
		end else begin
			st <= next_st;
		end
	end

	// Checks on the counter behaviour
	a_clear_to_zero: assert property (@(posedge clock) disable iff (!rst_n)
		!sync_clear_n |=> (count_value == 4'h0)) else $error("clear did not zero count");

	a_clear_beats_load: assert property (@(posedge clock) disable iff (!rst_n)
		(!sync_clear_n && !load_enable_n && count_enable_parallel) |=> (count_value == 4'h0))
		else $error("load or count overrode clear");

	a_load_copies: assert property (@(posedge clock) disable iff (!rst_n)
		(sync_clear_n && !load_enable_n && !st.sw_clear) |=> (count_value == $past(load_value)))
		else $error("load value not copied");

	a_count_steps: assert property (@(posedge clock) disable iff (!rst_n)
		(mode == SBC_MODE_COUNT && st.count_known) |=> (count_value == $past(count_value) + 4'h1))
		else $error("count did not increment");

	a_wrap_to_zero: assert property (@(posedge clock) disable iff (!rst_n)
		(mode == SBC_MODE_COUNT && count_value == 4'hf && st.count_known) ##1 sync_clear_n
		|-> (count_value == 4'h0)) else $error("count did not wrap");

	a_hold_stable: assert property (@(posedge clock) disable iff (!rst_n)
		(sync_clear_n && load_enable_n && !st.sw_clear && !st.sw_load
		&& !(count_enable_parallel && count_enable_trickle) && st.count_known)
		|=> $stable(count_value)) else $error("count moved while held");

	a_term_high: assert property (@(posedge clock) disable iff (!rst_n)
		(count_enable_trickle && st.count_known && $past(count_value) == 4'he
		&& $past(mode) == SBC_MODE_COUNT) |-> terminal_count) else $error("terminal count missing");

	a_term_low: assert property (@(posedge clock) disable iff (!rst_n)
		(!count_enable_trickle || (st.count_known && count_value != 4'hf)) |-> !terminal_count)
		else $error("terminal count spurious");

	a_change_by_mode: assert property (@(posedge clock) disable iff (!rst_n)
		(st.count_known && $past(st.count_known) && !$stable(count_value))
		|-> ($past(mode) != SBC_MODE_HOLD)) else $error("count changed without mode");

	a_sw_clear_acts: assert property (@(posedge clock) disable iff (!rst_n)
		st.sw_clear |=> (count_value == 4'h0 && !st.sw_clear)) else $error("software clear failed");

endmodule

// ---- test/sbc_ctl_model.sv ----
// Purpose: Control logic that sits in front of the counter pins
// Assumes: Bench changes mode and enables just after a rising edge
// Notes:   Purely combinational, so requests reach the pins in the same cycle
module sbc_ctl_model
	import sbc_pkg::*;
(
	// Requests from the bench
	input  wire sbc_mode_t   mode,
	input  wire logic        par_en_in,
	input  wire logic        tri_en_in,
	input  wire sbc_nibble_t value,
	// Counter pins
	output logic             sync_clear_n,
	output logic             load_enable_n,
	output logic             count_enable_parallel,
	output logic             count_enable_trickle,
	output sbc_nibble_t      load_value
);
	// terminal count unused
	// Terminal count is never a clock or reset here, so glitches on it are harmless
	always_comb begin
		// Clear also pulls load low, so that precedence is always stressed
		sync_clear_n          = (mode != SBC_MODE_CLEAR);
		load_enable_n         = (mode != SBC_MODE_CLEAR) && (mode != SBC_MODE_LOAD);
		count_enable_parallel = par_en_in;
		// single stage: trickle enable comes straight in, no ripple chain to settle
		count_enable_trickle  = tri_en_in;
		load_value            = value;
	end
endmodule

// ---- test/sbc_counter_tb_top.sv ----
// Purpose: Self-checking bench for the counter pins and its register port
// Assumes: Pins come from the control model; the bus is driven here
// Notes:   The count has no reset, so scenarios start from a clear or load
`include "sbc_params.svh"
module sbc_counter_tb_top
	import sbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock = 0, rst_n = 0, par_en_i = 0, tri_en_i = 0, term;
	sbc_mode_t   mode = SBC_MODE_COUNT;
	sbc_nibble_t val_i = 4'h0, ldv, cnt;
	logic        clr_n, ld_n, par_en, tri_en, awready, wready, bvalid, arready, rvalid;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	sbc_addr_t   awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [1:0]  bresp, rresp, r;
	int          err_count = 0, checked = 0;

	// Half-period toggle for 40 MHz
	always #12.5 clock = ~clock;

	sbc_ctl_model ctl (.mode(mode), .par_en_in(par_en_i), .tri_en_in(tri_en_i), .value(val_i),
		.sync_clear_n(clr_n), .load_enable_n(ld_n), .count_enable_parallel(par_en), .count_enable_trickle(tri_en),
		.load_value(ldv));

	sbc_counter dut (.clock(clock), .rst_n(rst_n), .sync_clear_n(clr_n), .load_enable_n(ld_n),
		.count_enable_parallel(par_en), .count_enable_trickle(tri_en), .load_value(ldv), .count_value(cnt),
		.terminal_count(term), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One pin operation: set after an edge, taken at the next, then back to idle
	task automatic op(input sbc_mode_t m, input logic p, input logic t, input sbc_nibble_t v);
		@(posedge clock);
		mode <= m;
		par_en_i <= p;
		tri_en_i <= t;
		val_i <= v;
		@(posedge clock);
		mode <= SBC_MODE_COUNT;
		par_en_i <= 1'b0;
		#1;
	endtask

	// Handshakes are judged at the falling edge, where everything has settled
	task automatic wr(input sbc_addr_t a, input logic [31:0] v);
		logic ha, hw, done;
		done = 0;
		@(posedge clock);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= v;
		bready <= 1'b1;
		while (!done) begin
			@(negedge clock);
			ha = awvalid && awready;
			hw = wvalid && wready;
			done = bvalid;
			r = bresp;
			@(posedge clock);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
			if (done) bready <= 1'b0;
		end
	endtask

	task automatic rd(input sbc_addr_t a);
		logic ha, done;
		done = 0;
		@(posedge clock);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		while (!done) begin
			@(negedge clock);
			ha = arvalid && arready;
			done = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clock);
			if (ha) arvalid <= 1'b0;
			if (done) rready <= 1'b0;
		end
	endtask

	task automatic end_sim;
		if (err_count == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// Register reset values, and the count still unknown
	task automatic t_reset;
		rd(`SBC_CTRL_OFS);
		chk("ctrl", d, 32'h4);
		rd(`SBC_PRESET_OFS);
		chk("preset", d, 32'h0);
		rd(`SBC_STATUS_OFS);
		chk("known", {31'h0, d[`SBC_STAT_KNOWN_BIT]}, 32'h0);
	endtask

	// Clear over load over count, load over count
	task automatic t_priority;
		op(SBC_MODE_CLEAR, 1'b1, 1'b1, 4'h9);
		chk("clear", cnt, 32'h0);
		op(SBC_MODE_LOAD, 1'b1, 1'b1, 4'ha);
		chk("load", cnt, 32'ha);
	endtask

	// Count to fifteen, hold on each enable low, then wrap
	task automatic t_count;
		op(SBC_MODE_LOAD, 1'b0, 1'b1, 4'he);
		op(SBC_MODE_COUNT, 1'b1, 1'b1, 4'h0);
		chk("count", cnt, 32'hf);
		chk("term", term, 32'h1);
		@(negedge clock);
		chk("falling", cnt, 32'hf);
		for (int i = 0; i < 3; i++) begin
			op(SBC_MODE_COUNT, i[0], i[1], 4'h0);
			chk("hold", cnt, 32'hf);
			chk("term gated", term, {31'h0, i[1]});
		end
		op(SBC_MODE_COUNT, 1'b1, 1'b1, 4'h0);
		chk("wrap", cnt, 32'h0);
		chk("term wrap", term, 32'h0);
	endtask

	// Gate, software load and clear, and unmapped addresses
	task automatic t_regs;
		wr(`SBC_PRESET_OFS, 32'h6);
		chk("bresp", r, `SBC_RESP_OKAY);
		wr(`SBC_CTRL_OFS, 32'h0);
		op(SBC_MODE_COUNT, 1'b1, 1'b1, 4'h0);
		chk("gated", cnt, 32'h0);
		wr(`SBC_CTRL_OFS, 32'h6);
		repeat (3) @(posedge clock);
		rd(`SBC_STATUS_OFS);
		chk("status", d, 32'h26);
		wr(`SBC_CTRL_OFS, 32'h5);
		repeat (3) @(posedge clock);
		#1;
		chk("sw clear", cnt, 32'h0);
		wr(4'hc, 32'h1);
		chk("bad wr", r, `SBC_RESP_SLVERR);
		rd(4'hc);
		chk("bad rd", {d[29:0], r}, {30'h0, `SBC_RESP_SLVERR});
	endtask

	// Main sequence
	initial begin
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		t_reset();
		t_priority();
		t_count();
		t_regs();
		end_sim();
	end

	// Watchdog, far beyond the sixty-odd cycles the run needs
	initial begin
		#(5000 * 25);
		err_count++;
		end_sim();
	end
endmodule
